// ===== verilog/rtcfo_regs.svh
`ifndef RTCFO_REGS_SVH
`define RTCFO_REGS_SVH

// Register offsets, bank 2
`define RTCFO_A_OFS_LO      4'h0
`define RTCFO_A_OFS_HI      4'h1
`define RTCFO_A_PRESET_LO   4'h4
`define RTCFO_A_PRESET_HI   4'h5
`define RTCFO_A_COUNT_LO    4'h6
`define RTCFO_A_COUNT_HI    4'h7
`define RTCFO_A_TSET        4'h8
// Register offsets, bank 1
`define RTCFO_A_CS_CTRL     4'hB
`define RTCFO_A_OUT_RATIO   4'hC
`define RTCFO_A_OUT_SET     4'hD
// Register offsets, all banks
`define RTCFO_A_FLAG_CTRL   4'hE
`define RTCFO_A_COMMON      4'hF

// Field positions
`define RTCFO_F_RUN         3
`define RTCFO_F_REPEAT      2
`define RTCFO_F_TFLAG       1
`define RTCFO_F_TIRQ_EN     0
`define RTCFO_F_AFLAG       1
`define RTCFO_F_AIRQ_EN     0
`define RTCFO_F_OUT_EN      3
`define RTCFO_F_OFS_EN      3
`define RTCFO_F_CS_IGNORE   2

// Reset values
`define RTCFO_RST_NIB       4'h0
`define RTCFO_RST_BYTE      8'h00
`define RTCFO_RST_PINS      13'h1FFF

// Prescaler bit whose carry gives each rate
`define RTCFO_P_4096        2
`define RTCFO_P_1024        4
`define RTCFO_P_64          8
`define RTCFO_P_32          9
`define RTCFO_P_1HZ         14

// Timing
`define RTCFO_MCLK_HZ       20000000
`define RTCFO_MCLK_NS       50
`define RTCFO_OSC_HALF_HZ   65536
`define RTCFO_RTN_SHORT_NS  122000
`define RTCFO_RTN_SHORT_CYC (`RTCFO_RTN_SHORT_NS / `RTCFO_MCLK_NS)
`define RTCFO_RTN_LONG_NS   7810000
`define RTCFO_OFS_SECONDS   10

`endif

// ===== verilog/rtcfo_pkg.sv
package rtcfo_pkg;

  typedef logic [3:0] rtcfo_nib_t;
  typedef logic [7:0] rtcfo_byte_t;

  typedef enum logic [2:0] {
    RTCFO_BANK0 = 3'h1,
    RTCFO_BANK1 = 3'h2,
    RTCFO_BANK2 = 3'h4
  } rtcfo_bank_t;

endpackage : rtcfo_pkg

// ===== verilog/rtcfo_top.sv
// Contract
// - Select pin high and output enabled: clock pin gives source over ratio.
// - Select pin high and output disabled: clock pin floats.
// - Select pin low: clock pin gives fixed 32.768 kHz, settings ignored.
// - Source field: 32768, 1024, 32 or 1 Hz into the output divider.
// - Ratio field divides by 1,2,3,6,5,10,15,30 with listed high fractions.
// - Timer is 8-bit down-counter on 4096 Hz, 64 Hz, seconds or minutes.
// - Writing either preset nibble loads the counter; preset is kept.
// - Reaching zero sets timer flag; writing zero clears, one does nothing.
// - Timer event drives interrupt low only with timer interrupt enabled.
// - Level mode holds interrupt low until the timer flag is cleared.
// - Repeat mode releases interrupt after 0.122 ms or 7.81 ms.
// - Level mode at zero clears run bit and stops with count zero.
// - Repeat mode at zero reloads the preset and counts again.
// - Count nibble registers read the live counter and ignore writes.
// - Run starts at write strobe rising edge; clearing run holds count.
// - A zero preset with run set never produces a timer interrupt.
// - Alarm and timer share one low pin, each gated by its own enable.
// - First period may be short by one source cycle; source is free.
// - Offset enabled: one second's count altered once every ten seconds.
// - Offset code 7-bit two's complement, 3.05 ppm steps.
// - Offset runs with chip select high unless the ignore bit is one.
// - Bank bits 00,01,10,11 map to banks 0,1,2,1.
`include "rtcfo_regs.svh"

module rtcfo_top #(
  parameter int unsigned RTN_LONG_CYC = `RTCFO_RTN_LONG_NS / `RTCFO_MCLK_NS
) (
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               rst,
  // Parallel bus pins
  input  wire logic               cs0_n,
  input  wire logic               chip_select_high_pin,
  input  wire logic               rd_n,
  input  wire logic               wr_n,
  input  wire rtcfo_pkg::rtcfo_nib_t addr,
  input  wire rtcfo_pkg::rtcfo_nib_t data_in,
  output rtcfo_pkg::rtcfo_nib_t   data_out,
  output logic                    data_oe,
  // Clock output pin
  input  wire logic               freq_select_pin,
  output logic                    fout,
  output logic                    fout_oe,
  // Interrupt pin, open drain
  output logic                    irq_out,
  output logic                    irq_oe,
  // Timekeeper events
  input  wire logic               alarm_event,
  input  wire logic               seconds_update,
  input  wire logic               minutes_update,
  output logic                    sec_tick
);
  import rtcfo_pkg::*;

  function automatic logic rtcfo_fall(input logic [14:0] a,
                                      input logic [14:0] b,
                                      input int          i);
    return a[i] & ~b[i];
  endfunction : rtcfo_fall

  function automatic logic [4:0] rtcfo_ratio(input logic [2:0] c);
    case (c)
      3'h0:    return 5'h01;
      3'h1:    return 5'h02;
      3'h2:    return 5'h03;
      3'h3:    return 5'h06;
      3'h4:    return 5'h05;
      3'h5:    return 5'h0A;
      3'h6:    return 5'h0F;
      default: return 5'h1E;
    endcase
  endfunction : rtcfo_ratio

  function automatic logic [4:0] rtcfo_high(input logic [2:0] c);
    case (c)
      3'h1:    return 5'h01;
      3'h2:    return 5'h01;
      3'h3:    return 5'h03;
      3'h4:    return 5'h01;
      3'h5:    return 5'h05;
      3'h6:    return 5'h05;
      3'h7:    return 5'h0F;
      default: return 5'h00;
    endcase
  endfunction : rtcfo_high

  function automatic rtcfo_bank_t rtcfo_bank(input logic [1:0] s);
    case (s)
      2'h0:    return RTCFO_BANK0;
      2'h2:    return RTCFO_BANK2;
      default: return RTCFO_BANK1;
    endcase
  endfunction : rtcfo_bank

  // Pin synchronisers
  logic [12:0] pin_s1;
  logic [12:0] pin_s2;
  logic        wr_prev;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pin_s1  <= `RTCFO_RST_PINS;
      pin_s2  <= `RTCFO_RST_PINS;
      wr_prev <= 1'b1;
    end
    else
    begin
      pin_s1  <= {cs0_n, chip_select_high_pin, rd_n, wr_n,
                  freq_select_pin, addr, data_in};
      pin_s2  <= pin_s1;
      wr_prev <= pin_s2[9];
    end
  end

  wire        cs0_s  = pin_s2[12];
  wire        csh_s  = pin_s2[11];
  wire        rd_s   = pin_s2[10];
  wire        wr_s   = pin_s2[9];
  wire        fsel_s = pin_s2[8];
  wire [3:0]  addr_s = pin_s2[7:4];
  wire [3:0]  dat_s  = pin_s2[3:0];
  wire        sel    = ~cs0_s & csh_s;
  wire        wr_stb = sel & wr_s & ~wr_prev;

  // Registers
  rtcfo_nib_t  rate_offset_low;
  rtcfo_nib_t  rate_offset_high;
  rtcfo_nib_t  timer_preset_low;
  rtcfo_nib_t  timer_preset_high;
  rtcfo_byte_t timer_count;
  rtcfo_nib_t  timer_settings;
  logic [2:0]  out_divider_select;
  logic        clock_out_enable;
  logic [1:0]  out_source_select;
  logic [1:0]  cs_ctrl;
  logic        timer_flag;
  logic        timer_irq_enable;
  logic        alarm_flag;
  logic        alarm_irq_enable;
  logic [1:0]  common_bits;
  logic [1:0]  bank_select;

  // Bank and address decode
  rtcfo_bank_t bank;
  assign bank = rtcfo_bank(bank_select);
  wire b1 = (bank == RTCFO_BANK1);
  wire b2 = (bank == RTCFO_BANK2);

  wire h_ofs_lo = b2 & (addr_s == `RTCFO_A_OFS_LO);
  wire h_ofs_hi = b2 & (addr_s == `RTCFO_A_OFS_HI);
  wire h_pre_lo = b2 & (addr_s == `RTCFO_A_PRESET_LO);
  wire h_pre_hi = b2 & (addr_s == `RTCFO_A_PRESET_HI);
  wire h_cnt_lo = b2 & (addr_s == `RTCFO_A_COUNT_LO);
  wire h_cnt_hi = b2 & (addr_s == `RTCFO_A_COUNT_HI);
  wire h_tset   = b2 & (addr_s == `RTCFO_A_TSET);
  wire h_tctl   = b2 & (addr_s == `RTCFO_A_FLAG_CTRL);
  wire h_csc    = b1 & (addr_s == `RTCFO_A_CS_CTRL);
  wire h_ratio  = b1 & (addr_s == `RTCFO_A_OUT_RATIO);
  wire h_oset   = b1 & (addr_s == `RTCFO_A_OUT_SET);
  wire h_actl   = b1 & (addr_s == `RTCFO_A_FLAG_CTRL);
  wire h_ctle   = (addr_s == `RTCFO_A_FLAG_CTRL);
  wire h_comm   = (addr_s == `RTCFO_A_COMMON);

  wire [3:0] rd_data =
      ({4{h_ofs_lo}} & rate_offset_low)
    | ({4{h_ofs_hi}} & rate_offset_high)
    | ({4{h_pre_lo}} & timer_preset_low)
    | ({4{h_pre_hi}} & timer_preset_high)
    | ({4{h_cnt_lo}} & timer_count[3:0])
    | ({4{h_cnt_hi}} & timer_count[7:4])
    | ({4{h_tset}}   & timer_settings)
    | ({4{h_tctl}}   & {2'h0, timer_flag, timer_irq_enable})
    | ({4{h_csc}}    & {cs_ctrl, 2'h0})
    | ({4{h_ratio}}  & {1'b0, out_divider_select})
    | ({4{h_oset}}   & {clock_out_enable, 1'b0, out_source_select})
    | ({4{h_actl}}   & {2'h0, alarm_flag, alarm_irq_enable})
    | ({4{h_ctle}}   & {common_bits, 2'h0})
    | ({4{h_comm}}   & {bank_select, 2'h0});

  // Bus read drive
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      data_out <= `RTCFO_RST_NIB;
      data_oe  <= 1'b0;
    end
    else
    begin
      data_out <= rd_data;
      data_oe  <= sel & ~rd_s;
    end
  end

  // Oscillator emulation and prescaler
  logic [24:0] nco_acc;
  logic        osc_sq;
  logic [14:0] presc;
  logic [6:0]  corr_cnt;
  logic        corr_skip;
  logic [3:0]  ten_cnt;

  wire [24:0] nco_sum   = nco_acc + 25'(`RTCFO_OSC_HALF_HZ);
  wire        half_tick = (nco_sum >= 25'(`RTCFO_MCLK_HZ));
  wire        tick32k   = half_tick & ~osc_sq;
  wire [1:0]  step      = (corr_cnt == 7'h00) ? 2'h1 :
                          (corr_skip ? 2'h0 : 2'h2);
  wire [14:0] presc_nx  = presc + {13'h0000, step};

  wire t4096 = tick32k & rtcfo_fall(presc, presc_nx, `RTCFO_P_4096);
  wire t64   = tick32k & rtcfo_fall(presc, presc_nx, `RTCFO_P_64);
  wire t1hz  = tick32k & rtcfo_fall(presc, presc_nx, `RTCFO_P_1HZ);

  // Rate offset
  wire [6:0] ofs_code   = {rate_offset_high[2:0], rate_offset_low};
  wire       ofs_sign   = rate_offset_high[2];
  wire [6:0] ofs_mag    = ofs_sign ? (7'h00 - ofs_code) : ofs_code;
  wire       ofs_active = rate_offset_high[`RTCFO_F_OFS_EN]
                        & (cs_ctrl[0] | csh_s);
  wire       ten_wrap   = t1hz & (ten_cnt == 4'(`RTCFO_OFS_SECONDS - 1));

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      nco_acc   <= 25'h000_0000;
      osc_sq    <= 1'b0;
      presc     <= 15'h0000;
      ten_cnt   <= `RTCFO_RST_NIB;
      corr_cnt  <= 7'h00;
      corr_skip <= 1'b0;
      sec_tick  <= 1'b0;
    end
    else
    begin
      nco_acc  <= half_tick ? nco_sum - 25'(`RTCFO_MCLK_HZ) : nco_sum;
      osc_sq   <= osc_sq ^ half_tick;
      sec_tick <= t1hz;
      if (tick32k)
      begin
        presc <= presc_nx;
      end
      if (t1hz)
      begin
        ten_cnt <= ten_wrap ? 4'h0 : ten_cnt + 4'h1;
      end
      if (ten_wrap & ofs_active)
      begin
        corr_cnt  <= ofs_mag;
        corr_skip <= ~ofs_sign;
      end
      else if (tick32k & (corr_cnt != 7'h00))
      begin
        corr_cnt <= corr_cnt - 7'h01;
      end
    end
  end

  // Timer
  wire        t_repeat = timer_settings[`RTCFO_F_REPEAT];
  wire [1:0]  t_src    = timer_settings[1:0];
  wire        src_tick = (t_src == 2'h0) ? t4096 :
                         (t_src == 2'h1) ? t64 :
                         (t_src == 2'h2) ? seconds_update :
                                           minutes_update;
  wire        tim_tick = timer_settings[`RTCFO_F_RUN] & src_tick;
  wire        zero_hit = tim_tick & (timer_count == 8'h01);
  wire [7:0]  preset   = {timer_preset_high, timer_preset_low};
  wire        w_pre_lo = wr_stb & h_pre_lo;
  wire        w_pre_hi = wr_stb & h_pre_hi;
  wire        w_tset   = wr_stb & h_tset;
  wire        w_tctl   = wr_stb & h_tctl;
  wire        w_actl   = wr_stb & h_actl;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      timer_preset_low  <= `RTCFO_RST_NIB;
      timer_preset_high <= `RTCFO_RST_NIB;
      timer_count       <= `RTCFO_RST_BYTE;
      timer_settings    <= `RTCFO_RST_NIB;
    end
    else
    begin
      if (w_pre_lo)
      begin
        timer_preset_low <= dat_s;
        timer_count      <= {timer_preset_high, dat_s};
      end
      else if (w_pre_hi)
      begin
        timer_preset_high <= dat_s;
        timer_count       <= {dat_s, timer_preset_low};
      end
      else if (zero_hit)
      begin
        timer_count <= t_repeat ? preset : 8'h00;
      end
      else if (tim_tick & (timer_count != 8'h00))
      begin
        timer_count <= timer_count - 8'h01;
      end
      if (w_tset)
      begin
        timer_settings <= dat_s;
      end
      else if (zero_hit & ~t_repeat)
      begin
        timer_settings[`RTCFO_F_RUN] <= 1'b0;
      end
    end
  end

  // Flags and control bits
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      timer_flag       <= 1'b0;
      timer_irq_enable <= 1'b0;
      alarm_flag       <= 1'b0;
      alarm_irq_enable <= 1'b0;
      rate_offset_low  <= `RTCFO_RST_NIB;
      rate_offset_high <= `RTCFO_RST_NIB;
      cs_ctrl          <= 2'h0;
      common_bits      <= 2'h0;
      bank_select      <= 2'h0;
    end
    else
    begin
      if (zero_hit)
      begin
        timer_flag <= 1'b1;
      end
      else if (w_tctl & ~dat_s[`RTCFO_F_TFLAG])
      begin
        timer_flag <= 1'b0;
      end
      if (alarm_event)
      begin
        alarm_flag <= 1'b1;
      end
      else if (w_actl & ~dat_s[`RTCFO_F_AFLAG])
      begin
        alarm_flag <= 1'b0;
      end
      if (w_tctl)
      begin
        timer_irq_enable <= dat_s[`RTCFO_F_TIRQ_EN];
      end
      if (w_actl)
      begin
        alarm_irq_enable <= dat_s[`RTCFO_F_AIRQ_EN];
      end
      if (wr_stb & h_ofs_lo)
      begin
        rate_offset_low <= dat_s;
      end
      if (wr_stb & h_ofs_hi)
      begin
        rate_offset_high <= dat_s;
      end
      if (wr_stb & h_csc)
      begin
        cs_ctrl <= dat_s[3:2];
      end
      if (wr_stb & h_ctle)
      begin
        common_bits <= dat_s[3:2];
      end
      if (wr_stb & h_comm)
      begin
        bank_select <= dat_s[3:2];
      end
    end
  end

  // Interrupt pin
  logic [17:0] rtn_cnt;
  wire  [17:0] rtn_load = (t_src == 2'h0) ? 18'(`RTCFO_RTN_SHORT_CYC)
                                          : 18'(RTN_LONG_CYC);
  wire irq_timer_lvl = timer_flag & timer_irq_enable & ~t_repeat;
  wire irq_alarm     = alarm_flag & alarm_irq_enable;
  wire next_irq_low  = irq_alarm | irq_timer_lvl
                     | (rtn_cnt != 18'h0_0000);

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rtn_cnt <= 18'h0_0000;
      irq_out <= 1'b0;
      irq_oe  <= 1'b0;
    end
    else
    begin
      irq_out <= 1'b0;
      irq_oe  <= next_irq_low;
      if (zero_hit & t_repeat & timer_irq_enable)
      begin
        rtn_cnt <= rtn_load;
      end
      else if (rtn_cnt != 18'h0_0000)
      begin
        rtn_cnt <= rtn_cnt - 18'h0_0001;
      end
    end
  end

  // Clock output divider
  logic       src_prev;
  logic [4:0] div_cnt;
  wire        src_sq  = (out_source_select == 2'h0) ? osc_sq :
                        (out_source_select == 2'h1) ? presc[`RTCFO_P_1024] :
                        (out_source_select == 2'h2) ? presc[`RTCFO_P_32] :
                                                      presc[`RTCFO_P_1HZ];
  wire        src_up  = src_sq & ~src_prev;
  wire [4:0]  ratio   = rtcfo_ratio(out_divider_select);
  wire        div_out = (ratio == 5'h01) ? src_sq
                      : (div_cnt < rtcfo_high(out_divider_select));

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      out_divider_select <= 3'h0;
      clock_out_enable   <= 1'b0;
      out_source_select  <= 2'h0;
      src_prev           <= 1'b0;
      div_cnt            <= 5'h00;
      fout               <= 1'b0;
      fout_oe            <= 1'b0;
    end
    else
    begin
      if (wr_stb & h_ratio)
      begin
        out_divider_select <= dat_s[2:0];
      end
      if (wr_stb & h_oset)
      begin
        clock_out_enable  <= dat_s[`RTCFO_F_OUT_EN];
        out_source_select <= dat_s[1:0];
      end
      src_prev <= src_sq;
      if (src_up)
      begin
        div_cnt <= (div_cnt >= ratio - 5'h01) ? 5'h00 : div_cnt + 5'h01;
      end
      fout    <= fsel_s ? (clock_out_enable & div_out) : osc_sq;
      fout_oe <= ~fsel_s | clock_out_enable;
    end
  end

endmodule : rtcfo_top

// ===== tb/rtcfo_monitor.sv
module rtcfo_monitor (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Bus pins
  input wire logic cs0_n,
  input wire logic chip_select_high_pin,
  input wire logic rd_n,
  input wire logic data_oe,
  // Output pins
  input wire logic freq_select_pin,
  input wire logic fout,
  input wire logic fout_oe,
  input wire logic irq_out,
  input wire logic irq_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  irq_drive_a: assert property (irq_oe |-> !irq_out)
    else $error("interrupt pin enabled without low drive");
  fixed_drive_a: assert property ((!freq_select_pin)[*4] |=> fout_oe)
    else $error("clock pin not driven with select pin low");
  fixed_toggle_a: assert property ((!freq_select_pin)[*8] |->
    ##[1:320] ($changed(fout) || freq_select_pin))
    else $error("fixed clock output stuck");
  read_cause_a: assert property ($rose(data_oe) |->
    $past(!rd_n && !cs0_n, 2))
    else $error("bus driven without read strobe");
  read_answer_a: assert property
    ((!rd_n && !cs0_n && chip_select_high_pin)[*4] |-> data_oe)
    else $error("read not answered in three cycles");
  read_drop_a: assert property (rd_n[*5] |-> !data_oe)
    else $error("bus still driven after read");
  cs_drop_a: assert property (cs0_n[*5] |-> !data_oe)
    else $error("bus driven while deselected");
  cs_high_drop_a: assert property
    ((!chip_select_high_pin)[*5] |-> !data_oe)
    else $error("bus driven with high select low");
endmodule : rtcfo_monitor

bind rtcfo_top rtcfo_monitor mon (
  .mclk(mclk), .rst(rst), .cs0_n(cs0_n),
  .chip_select_high_pin(chip_select_high_pin), .rd_n(rd_n),
  .data_oe(data_oe), .freq_select_pin(freq_select_pin),
  .fout(fout), .fout_oe(fout_oe), .irq_out(irq_out), .irq_oe(irq_oe)
);

// ===== tb/rtcfo_host.sv
module rtcfo_host (
  // Clock
  input  wire logic                  mclk,
  // Bus pins
  output logic                       cs0_n,
  output logic                       chip_select_high_pin,
  output logic                       rd_n,
  output logic                       wr_n,
  output rtcfo_pkg::rtcfo_nib_t      addr,
  output rtcfo_pkg::rtcfo_nib_t      data_in,
  // Read return
  input  wire rtcfo_pkg::rtcfo_nib_t data_out,
  input  wire logic                  data_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  import rtcfo_pkg::*;

  initial
  begin
    cs0_n = 1'b1;
    chip_select_high_pin = 1'b0;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr = 4'h0;
    data_in = 4'h0;
  end

  // Select the device just after an edge
  task automatic sel(input rtcfo_nib_t a);
    @(posedge mclk);
    addr <= a;
    cs0_n <= 1'b0;
    chip_select_high_pin <= 1'b1;
  endtask : sel

  // Released data lines show the inverse of the last value
  task automatic wr(input rtcfo_nib_t a, input rtcfo_nib_t d);
    sel(a);
    data_in <= d;
    wr_n <= 1'b0;
    repeat (4) @(posedge mclk);
    wr_n <= 1'b1;
    repeat (4) @(posedge mclk);
    cs0_n <= 1'b1;
    chip_select_high_pin <= 1'b0;
    data_in <= ~d;
  endtask : wr

  task automatic rd(input rtcfo_nib_t a, output rtcfo_nib_t d);
    int n;
    n = 0;
    sel(a);
    rd_n <= 1'b0;
    while (data_oe !== 1'b1 && n < 20)
    begin
      @(posedge mclk);
      n++;
    end
    d = data_out;
    rd_n <= 1'b1;
    cs0_n <= 1'b1;
    chip_select_high_pin <= 1'b0;
    repeat (5) @(posedge mclk);
  endtask : rd
endmodule : rtcfo_host

// ===== tb/rtcfo_top_tb.sv
module rtcfo_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rtcfo_pkg::*;

  logic       mclk, rst, fsel, cs0_n, cs_hi, rd_n, wr_n;
  logic       doe, fout, fout_oe, irq_out, irq_oe;
  logic [2:0] ev;
  rtcfo_nib_t addr, din, dout, v;
  int         n_mismatch, n_checks, n, cyc;
  int         rat[5] = '{1, 2, 3, 6, 5};
  int         den[5] = '{2, 2, 3, 2, 5};

  rtcfo_top #(.RTN_LONG_CYC(200)) DUT (
    .mclk(mclk), .rst(rst), .cs0_n(cs0_n),
    .chip_select_high_pin(cs_hi), .rd_n(rd_n), .wr_n(wr_n),
    .addr(addr), .data_in(din), .data_out(dout), .data_oe(doe),
    .freq_select_pin(fsel), .fout(fout), .fout_oe(fout_oe),
    .irq_out(irq_out), .irq_oe(irq_oe), .alarm_event(ev[0]),
    .seconds_update(ev[1]), .minutes_update(ev[2]), .sec_tick()
  );
  rtcfo_host host (
    .mclk(mclk), .cs0_n(cs0_n), .chip_select_high_pin(cs_hi),
    .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .data_in(din),
    .data_out(dout), .data_oe(doe)
  );

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 100000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  task automatic chk(input string s, input rtcfo_nib_t e, rtcfo_nib_t g);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  // Cycle counts, two cycles of oscillator jitter allowed
  task automatic chk_cnt(input string s, input int e, input int g);
    n_checks++;
    if (g < e - 2 || g > e + 2)
    begin
      n_mismatch++;
      $display("ERROR %s expected %0d seen %0d", s, e, g);
    end
  endtask : chk_cnt

  task automatic rdc(input string s, input rtcfo_nib_t a, rtcfo_nib_t e);
    host.rd(a, v);
    chk(s, e, v);
  endtask : rdc

  task automatic tk;
    @(posedge mclk);
    n++;
  endtask : tk

  task automatic wait_irq(input string s, input logic l, input int lim);
    n = 0;
    while (irq_oe !== l && n < lim)
      tk();
    chk(s, {3'h0, l}, {3'h0, irq_oe});
  endtask : wait_irq

  task automatic pulse(input int i);
    @(posedge mclk);
    ev[i] <= 1'b1;
    @(posedge mclk);
    ev[i] <= 1'b0;
  endtask : pulse

  task automatic meas(input int r, input int d);
    real p;
    int  h;
    p = r * 20.0e6 / 32768.0;
    // Let the new ratio reach the pin before looking for an edge
    repeat (2) @(posedge mclk);
    n = 0;
    while (fout !== 1'b0 && n < 40000)
      tk();
    while (fout !== 1'b1 && n < 40000)
      tk();
    n = 0;
    while (fout === 1'b1 && n < 40000)
      tk();
    h = n;
    while (fout !== 1'b1 && n < 40000)
      tk();
    chk_cnt("fout high", $rtoi(p / d + 0.5), h);
    chk_cnt("fout period", $rtoi(p + 0.5), n);
  endtask : meas

  initial
  begin
    rst = 1'b1;
    fsel = 1'b1;
    ev = 3'h0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    host.wr(4'hF, 4'h8);
    rdc("preset reset", 4'h4, 4'h0);
    host.wr(4'h1, 4'h7);
    rdc("offset high", 4'h1, 4'h7);
    host.wr(4'h4, 4'h2);
    host.wr(4'h5, 4'h0);
    rdc("preset low", 4'h4, 4'h2);
    rdc("count low", 4'h6, 4'h2);
    host.wr(4'h6, 4'h9);
    rdc("count read only", 4'h6, 4'h2);
    $display("test registers done");
    host.wr(4'hE, 4'h1);
    host.wr(4'h8, 4'h8);
    wait_irq("level irq", 1'b1, 12000);
    rdc("flag set", 4'hE, 4'h3);
    rdc("run cleared", 4'h8, 4'h0);
    rdc("count zero", 4'h6, 4'h0);
    rdc("preset kept", 4'h4, 4'h2);
    host.wr(4'hE, 4'h3);
    rdc("flag kept", 4'hE, 4'h3);
    wait_irq("irq held", 1'b1, 1);
    host.wr(4'hE, 4'h1);
    wait_irq("irq cleared", 1'b0, 10);
    $display("test level mode done");
    host.wr(4'h4, 4'h1);
    host.wr(4'h8, 4'hC);
    wait_irq("repeat irq", 1'b1, 6000);
    wait_irq("repeat release", 1'b0, 3000);
    chk_cnt("short release", 2440, n);
    rdc("reload", 4'h6, 4'h1);
    rdc("flag repeat", 4'hE, 4'h3);
    wait_irq("second irq", 1'b1, 6000);
    wait_irq("second release", 1'b0, 3000);
    host.wr(4'h8, 4'h0);
    host.wr(4'hE, 4'h1);
    host.wr(4'h4, 4'h1);
    host.wr(4'h8, 4'hE);
    pulse(1);
    wait_irq("seconds irq", 1'b1, 10);
    wait_irq("long release", 1'b0, 400);
    chk_cnt("long release", 200, n);
    host.wr(4'h8, 4'h0);
    host.wr(4'hE, 4'h1);
    host.wr(4'h4, 4'h1);
    host.wr(4'h8, 4'hB);
    pulse(1);
    repeat (5) @(posedge mclk);
    wait_irq("seconds ignored", 1'b0, 1);
    pulse(2);
    wait_irq("minutes irq", 1'b1, 10);
    host.wr(4'hE, 4'h1);
    $display("test repeat mode done");
    host.wr(4'h4, 4'h0);
    host.wr(4'h8, 4'h8);
    repeat (6000) @(posedge mclk);
    wait_irq("zero preset", 1'b0, 1);
    rdc("no flag", 4'hE, 4'h1);
    host.wr(4'h4, 4'hF);
    host.wr(4'h5, 4'hF);
    repeat (6000) @(posedge mclk);
    host.wr(4'h8, 4'h0);
    host.rd(4'h6, v);
    chk("count ran", 4'h1, {3'h0, v < 4'hF});
    repeat (6000) @(posedge mclk);
    rdc("count held", 4'h6, v);
    $display("test run control done");
    host.wr(4'hE, 4'h0);
    host.wr(4'hF, 4'h4);
    host.wr(4'hE, 4'h1);
    pulse(0);
    wait_irq("alarm irq", 1'b1, 10);
    rdc("alarm flag", 4'hE, 4'h3);
    host.wr(4'hE, 4'h1);
    wait_irq("alarm clear", 1'b0, 10);
    $display("test alarm done");
    host.wr(4'hF, 4'hC);
    host.wr(4'hD, 4'h3);
    host.wr(4'hF, 4'h4);
    rdc("bank alias", 4'hD, 4'h3);
    chk("output floats", 4'h0, {3'h0, fout_oe});
    fsel <= 1'b0;
    repeat (5) @(posedge mclk);
    chk("fixed drive", 4'h1, {3'h0, fout_oe});
    meas(1, 2);
    fsel <= 1'b1;
    host.wr(4'hD, 4'h8);
    for (int i = 0; i < 5; i++)
    begin
      host.wr(4'hC, 4'(i));
      meas(rat[i], den[i]);
    end
    for (int s = 1; s < 4; s++)
    begin
      host.wr(4'hD, 4'h8 | 4'(s));
      chk("source drive", 4'h1, {3'h0, fout_oe});
    end
    host.wr(4'hF, 4'h0);
    rdc("bank 0", 4'hD, 4'h0);
    $display("test clock output done");
    print_verdict();
  end
endmodule : rtcfo_top_tb
